// File: src/sfrm_pkg.sv
// Shared constants and types of the supply fault and reset monitor
package sfrm_pkg;
  localparam int DW = 16;
  localparam int AW = 3;
  ////////////////////////////////////////////////////////////////////////////
  // Device register indices on the link
  localparam logic [2:0] IDX_FAULT1 = 3'h0;
  localparam logic [2:0] IDX_FAULT2 = 3'h1;
  localparam logic [2:0] IDX_MASK1 = 3'h2;
  localparam logic [2:0] IDX_SYSCFG1 = 3'h3;
  localparam logic [2:0] IDX_THRESH = 3'h4;
  // first_fault_status fields
  localparam int F1_POR = 0;
  localparam int F1_RESET = 1;
  localparam int F1_STK_OV = 2;
  localparam int F1_STK_LV = 3;
  // second_fault_status fields
  localparam int F2_COMM_UV = 0;
  localparam int F2_COMM_OV = 1;
  localparam int F2_ANA_UV = 2;
  localparam int F2_ANA_OV = 3;
  localparam int F2_MEAS_OV = 4;
  localparam int F2_W = 5;
  // first_fault_mask: low bits mask status 1, from this bit status 2
  localparam int MASK_F2_LSB = 8;
  // first_system_config fields
  localparam int CFG_SOFT_RST = 0;
  localparam int CFG_SOC = 1;
  localparam int CFG_PER_LSB = 4;
  localparam int CFG_PER_W = 3;
  // Implemented bits and reset values
  localparam logic [15:0] F1_IMPL = 16'h000f;
  localparam logic [15:0] F2_IMPL = 16'h001f;
  localparam logic [15:0] MASK1_IMPL = 16'h1f0f;
  localparam logic [15:0] CFG1_IMPL = 16'h0070;
  localparam logic [15:0] FAULT1_POR_VAL = 16'h0001;
  localparam logic [15:0] F1_KEEP = 16'h000c;
  localparam logic [15:0] F1_RST_SET = 16'h0002;
  localparam logic [15:0] FAULT2_RST_VAL = 16'h0000;
  localparam logic [15:0] MASK1_RST_VAL = 16'h0000;
  localparam logic [15:0] CFG1_RST_VAL = 16'h0000;
  localparam logic [15:0] THRESH_RST_VAL = 16'hffff;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SUPPLY_FILTER_NS = 1000;
  localparam int RESET_FILTER_NS = 1000;
  localparam int REG_RETRY_NS = 10000;
  localparam int PERIOD_UNIT_NS = 10000;
  localparam int SEQ_LEN_NS = 320;
  localparam int SUPPLY_READY_NS = 5000000;
  localparam int SUPPLY_FILTER_CYC =
    (SUPPLY_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_FILTER_CYC =
    (RESET_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REG_RETRY_CYC =
    (REG_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERIOD_UNIT_CYC = PERIOD_UNIT_NS / CLK_PERIOD_NS;
  localparam int SEQ_LEN_CYC = (SEQ_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUPPLY_READY_CYC =
    (SUPPLY_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  ////////////////////////////////////////////////////////////////////////////
  // Controller Avalon word indices and command fields
  localparam logic [1:0] HOST_CMD_IDX = 2'h0;
  localparam logic [1:0] HOST_STAT_IDX = 2'h1;
  localparam logic [1:0] HOST_RDATA_IDX = 2'h2;
  localparam logic [1:0] HOST_RSTPIN_IDX = 2'h3;
  localparam int CMD_WDATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_WE_BIT = 24;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} sfrm_seq_t;
endpackage

// File: src/sfrm_link_if.sv
// Link between the monitor device and its controller
`timescale 1ns/1ps
interface sfrm_link_if;
  logic req;
  logic we;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic reset_pin;
  logic fault_pin;
  modport dev (input req, we, addr, wdata, reset_pin,
               output ack, rdata, fault_pin);
  modport ctrl (output req, we, addr, wdata, reset_pin,
                input ack, rdata, fault_pin);
endinterface

// File: src/sfrm_device.sv
// Supply fault and reset monitor, device end
`timescale 1ns/1ps
// Functional notes
// - Nonzero period timer starts sequences autonomously
// - Cyclic sequence compares channel against threshold
// - Flags readable and routable to fault pin
// - Start-of-conversion command runs one sequence
// - Stack overvoltage flagged after filter period
// - Unmasked stack overvoltage flag drives fault high
// - Stack overvoltage only flags, never resets
// - Stack overvoltage flag cleared by writing zero
// - Low-voltage flag clears only when back in range
// - Comm regulator limit sets flag, retry cycle
// - Comm undervoltage faults latched until controller clears
// - Comm overvoltage comparator sets its flag
// - Analog regulator limit sets flag, retry cycle
// - Analog overvoltage checked during every sequence
// - Stack undervoltage holds reset, recovery is power-on
// - Logic supply drop triggers full power-on reset
// - Power-on: defaults, power-on flag, fault active
// - Reset pin high beyond filter time resets
// - Software reset bit write resets device
// - Pin and software resets set reset flag
// - Controller waits ready interval after pin or software reset
// - Registers are sixteen bits wide with fields
// - Pin and software resets keep some first status bits
module sfrm_device
  import sfrm_pkg::*;
#(
  parameter int FILT_CYC = SUPPLY_FILTER_CYC,
  parameter int RST_FILT_CYC = RESET_FILTER_CYC,
  parameter int RETRY_CYC = REG_RETRY_CYC,
  parameter int UNIT_CYC = PERIOD_UNIT_CYC,
  parameter int SEQ_CYC = SEQ_LEN_CYC
) (
  input wire logic clock_i, // System clock
  input wire logic arst_n_i, // Power-on reset, active low
  input wire logic ce_i, // Clock enable
  sfrm_link_if.dev link, // Link to controller
  input wire logic stack_ov_cmp_i, // Stack supply overvoltage comparator
  input wire logic stack_lv_cmp_i, // Stack supply low-voltage comparator
  input wire logic stack_uv_cmp_i, // Stack supply undervoltage comparator
  input wire logic logic_supply_low_i, // Digital supply below safe level
  input wire logic comm_ilim_uv_i, // Comm regulator limit and undervoltage
  input wire logic comm_ov_cmp_i, // Comm regulator overvoltage
  input wire logic ana_ilim_uv_i, // Analog regulator limit and undervolt
  input wire logic ana_ov_cmp_i, // Analog supply overvoltage
  input wire logic [15:0] meas_value_i, // Selected measured channel
  output logic comm_reg_en_o, // Comm regulator enabled
  output logic ana_reg_en_o, // Analog regulator enabled
  output logic seq_busy_o, // Measurement sequence running
  output logic seq_done_o, // Sequence finished, one cycle
  output logic in_reset_o // Device held in internal reset
);
  logic ack_r;
  logic fault_r;
  logic rst_ind_r;
  logic seq_done_r;
  logic [15:0] rdata_r;
  logic [15:0] fault1_r;
  logic [15:0] fault2_r;
  logic [15:0] mask1_r;
  logic [15:0] cfg1_r;
  logic [15:0] thresh_r;
  logic [15:0] ofilt_r;
  logic [15:0] rfilt_r;
  logic [31:0] tmr_r;
  logic [15:0] seq_cnt_r;
  logic seq_cyc_r;
  sfrm_seq_t seq_st_r;
  sfrm_seq_t seq_st_nxt;
  logic [15:0] seq_cnt_nxt;
  logic seq_cyc_nxt;
  logic [15:0] f1_nxt;
  logic [15:0] f2_nxt;
  logic reg_on_r [2];
  logic [15:0] retry_r [2];

  ////////////////////////////////////////////////////////////////////////////
  // Link decode and reset sources
  wire por_hold = stack_uv_cmp_i | logic_supply_low_i;
  wire acc_new = link.req & ~ack_r;
  wire wr_fire = acc_new & link.we;
  wire wr_f1 = wr_fire & (link.addr == IDX_FAULT1);
  wire wr_f2 = wr_fire & (link.addr == IDX_FAULT2);
  wire wr_m1 = wr_fire & (link.addr == IDX_MASK1);
  wire wr_cfg = wr_fire & (link.addr == IDX_SYSCFG1);
  wire wr_thr = wr_fire & (link.addr == IDX_THRESH);
  wire soft_fire = wr_cfg & link.wdata[CFG_SOFT_RST];
  wire soc_fire = wr_cfg & link.wdata[CFG_SOC];
  wire pin_fire = link.reset_pin & (rfilt_r == 16'(RST_FILT_CYC));
  wire warm_rst = pin_fire | soft_fire;
  wire [15:0] rfilt_nxt = !link.reset_pin ? 16'h0000 :
    (rfilt_r > 16'(RST_FILT_CYC)) ? rfilt_r : rfilt_r + 16'h0001;
  wire [15:0] ofilt_nxt = !stack_ov_cmp_i ? 16'h0000 :
    (ofilt_r > 16'(FILT_CYC)) ? ofilt_r : ofilt_r + 16'h0001;
  wire stk_ov_set = stack_ov_cmp_i & (ofilt_r >= 16'(FILT_CYC));
  wire [15:0] rd_mux =
    (link.addr == IDX_FAULT1) ? fault1_r :
    (link.addr == IDX_FAULT2) ? fault2_r :
    (link.addr == IDX_MASK1) ? mask1_r :
    (link.addr == IDX_SYSCFG1) ? cfg1_r :
    (link.addr == IDX_THRESH) ? thresh_r : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Regulator shutdown and retry
  wire [1:0] ilim = {ana_ilim_uv_i, comm_ilim_uv_i};
  wire [1:0] uv_evt = ilim & {reg_on_r[1], reg_on_r[0]};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_retry
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          reg_on_r[g] <= 1'b1;
          retry_r[g] <= 16'h0000;
        end else if (ce_i) begin
          if (uv_evt[g]) begin
            reg_on_r[g] <= 1'b0;
            retry_r[g] <= 16'(RETRY_CYC - 1);
          end else if (!reg_on_r[g]) begin
            if (retry_r[g] == 16'h0000) begin
              reg_on_r[g] <= 1'b1;
            end else begin
              retry_r[g] <= retry_r[g] - 16'h0001;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Period timer and measurement sequencer
  wire [2:0] per_sel = cfg1_r[CFG_PER_LSB +: CFG_PER_W];
  wire [31:0] per_lim = 32'(per_sel) * 32'(UNIT_CYC);
  wire tmr_exp = (per_sel != 3'h0) & (tmr_r >= per_lim - 32'h1);
  wire [31:0] tmr_nxt = (per_sel == 3'h0 || tmr_exp) ? 32'h0 :
    tmr_r + 32'h1;
  wire start_cyc = tmr_exp & (seq_st_r == SEQ_IDLE) & ~soc_fire;
  wire seq_end = (seq_st_r == SEQ_RUN) & (seq_cnt_r == 16'h0000) &
    ~soc_fire;
  wire meas_ov_set = seq_end & seq_cyc_r & (meas_value_i > thresh_r);
  wire ana_ov_set = (seq_st_r == SEQ_RUN) & ana_ov_cmp_i;

  always_comb begin
    seq_st_nxt = seq_st_r;
    seq_cnt_nxt = seq_cnt_r;
    seq_cyc_nxt = seq_cyc_r;
    case (seq_st_r)
      SEQ_IDLE: begin
        if (soc_fire || start_cyc) begin
          seq_st_nxt = SEQ_RUN;
          seq_cnt_nxt = 16'(SEQ_CYC - 1);
          seq_cyc_nxt = start_cyc;
        end
      end
      SEQ_RUN: begin
        if (soc_fire) begin
          seq_cnt_nxt = 16'(SEQ_CYC - 1);
          seq_cyc_nxt = 1'b0;
        end else if (seq_cnt_r == 16'h0000) begin
          seq_st_nxt = SEQ_IDLE;
        end else begin
          seq_cnt_nxt = seq_cnt_r - 16'h0001;
        end
      end
      default: begin
        seq_st_nxt = SEQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags: write zero clears, a set in the same cycle wins
  always_comb begin
    f1_nxt = wr_f1 ? (fault1_r & link.wdata) : fault1_r;
    f1_nxt[F1_STK_OV] = f1_nxt[F1_STK_OV] | stk_ov_set;
    f1_nxt[F1_STK_LV] = f1_nxt[F1_STK_LV] | stack_lv_cmp_i;
    f2_nxt = wr_f2 ? (fault2_r & link.wdata) : fault2_r;
    f2_nxt[F2_COMM_UV] = f2_nxt[F2_COMM_UV] | uv_evt[0];
    f2_nxt[F2_COMM_OV] = f2_nxt[F2_COMM_OV] | comm_ov_cmp_i;
    f2_nxt[F2_ANA_UV] = f2_nxt[F2_ANA_UV] | uv_evt[1];
    f2_nxt[F2_ANA_OV] = f2_nxt[F2_ANA_OV] | ana_ov_set;
    f2_nxt[F2_MEAS_OV] = f2_nxt[F2_MEAS_OV] | meas_ov_set;
  end

  wire [15:0] mask2 = mask1_r >> MASK_F2_LSB;
  wire fault_any = (|(fault1_r & ~mask1_r & F1_IMPL)) |
    (|(fault2_r & ~mask2 & F2_IMPL));

  ////////////////////////////////////////////////////////////////////////////
  // Register file and reset handling
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
      fault_r <= 1'b1;
      rst_ind_r <= 1'b1;
      rfilt_r <= 16'h0000;
      ofilt_r <= 16'h0000;
      fault1_r <= FAULT1_POR_VAL;
      fault2_r <= FAULT2_RST_VAL;
      mask1_r <= MASK1_RST_VAL;
      cfg1_r <= CFG1_RST_VAL;
      thresh_r <= THRESH_RST_VAL;
      tmr_r <= 32'h0;
      seq_st_r <= SEQ_IDLE;
      seq_cnt_r <= 16'h0000;
      seq_cyc_r <= 1'b0;
      seq_done_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= acc_new;
      rdata_r <= acc_new ? rd_mux : rdata_r;
      fault_r <= fault_any;
      rst_ind_r <= por_hold | warm_rst;
      rfilt_r <= rfilt_nxt;
      ofilt_r <= ofilt_nxt;
      seq_done_r <= seq_end & ~por_hold & ~warm_rst;
      if (por_hold) begin
        fault1_r <= FAULT1_POR_VAL;
        fault2_r <= FAULT2_RST_VAL;
        mask1_r <= MASK1_RST_VAL;
        cfg1_r <= CFG1_RST_VAL;
        thresh_r <= THRESH_RST_VAL;
        tmr_r <= 32'h0;
        seq_st_r <= SEQ_IDLE;
        seq_cyc_r <= 1'b0;
      end else if (warm_rst) begin
        fault1_r <= (fault1_r & F1_KEEP) | F1_RST_SET;
        fault2_r <= FAULT2_RST_VAL;
        mask1_r <= MASK1_RST_VAL;
        cfg1_r <= CFG1_RST_VAL;
        thresh_r <= THRESH_RST_VAL;
        tmr_r <= 32'h0;
        seq_st_r <= SEQ_IDLE;
        seq_cyc_r <= 1'b0;
      end else begin
        fault1_r <= f1_nxt & F1_IMPL;
        fault2_r <= f2_nxt & F2_IMPL;
        mask1_r <= wr_m1 ? (link.wdata & MASK1_IMPL) : mask1_r;
        cfg1_r <= wr_cfg ? (link.wdata & CFG1_IMPL) : cfg1_r;
        thresh_r <= wr_thr ? link.wdata : thresh_r;
        tmr_r <= tmr_nxt;
        seq_st_r <= seq_st_nxt;
        seq_cnt_r <= seq_cnt_nxt;
        seq_cyc_r <= seq_cyc_nxt;
      end
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign link.fault_pin = fault_r;
  assign comm_reg_en_o = reg_on_r[0];
  assign ana_reg_en_o = reg_on_r[1];
  assign seq_busy_o = (seq_st_r == SEQ_RUN);
  assign seq_done_o = seq_done_r;
  assign in_reset_o = rst_ind_r;
endmodule // sfrm_device

// File: src/sfrm_ctrl.sv
// Supply fault and reset monitor, controller end with Avalon-MM slave
`timescale 1ns/1ps
module sfrm_ctrl
  import sfrm_pkg::*;
#(
  parameter int READY_CYC = SUPPLY_READY_CYC
) (
  input wire logic clock_i, // System clock
  input wire logic arst_n_i, // Asynchronous reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic [1:0] avs_address_i, // Word index
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Slave not ready
  sfrm_link_if.ctrl link // Link to device
);
  logic ack_r;
  logic busy_r;
  logic req_r;
  logic we_r;
  logic rst_pin_r;
  logic soft_pend_r;
  logic [2:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic [31:0] rd_r;
  logic [31:0] ready_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire acc = avs_read_i | avs_write_i;
  wire cmd_sel = (avs_address_i == HOST_CMD_IDX);
  wire wait_rdy = (ready_r != 32'h0);
  wire stall = avs_write_i & cmd_sel & (busy_r | wait_rdy);
  wire take = acc & ack_r;
  wire cmd_go = take & avs_write_i & cmd_sel;
  wire pin_wr = take & avs_write_i & (avs_address_i == HOST_RSTPIN_IDX);
  wire [2:0] cmd_addr = avs_writedata_i[CMD_ADDR_LSB +: AW];
  wire cmd_we = avs_writedata_i[CMD_WE_BIT];
  wire cmd_soft = cmd_we & (cmd_addr == IDX_SYSCFG1) &
    avs_writedata_i[CMD_WDATA_LSB + CFG_SOFT_RST];
  wire done = req_r & link.ack;
  wire [31:0] stat = {28'h0, rst_pin_r, wait_rdy, link.fault_pin, busy_r};
  wire [31:0] rd_mux =
    (avs_address_i == HOST_CMD_IDX) ? {7'h0, we_r, 5'h0, addr_r, wdata_r} :
    (avs_address_i == HOST_STAT_IDX) ? stat :
    (avs_address_i == HOST_RDATA_IDX) ? {16'h0, rdata_r} :
    {31'h0, rst_pin_r};
  wire [31:0] ready_nxt = rst_pin_r ? 32'(READY_CYC) :
    (done & soft_pend_r) ? 32'(READY_CYC) :
    wait_rdy ? ready_r - 32'h1 : ready_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command and link state
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r <= 1'b0;
      busy_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      rst_pin_r <= 1'b0;
      soft_pend_r <= 1'b0;
      addr_r <= 3'h0;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      rd_r <= 32'h0;
      ready_r <= 32'h0;
    end else if (ce_i) begin
      ack_r <= acc & ~stall & ~ack_r;
      rd_r <= (acc & ~ack_r) ? rd_mux : rd_r;
      ready_r <= ready_nxt;
      rst_pin_r <= pin_wr ? avs_writedata_i[0] : rst_pin_r;
      if (cmd_go) begin
        busy_r <= 1'b1;
        req_r <= 1'b1;
        we_r <= cmd_we;
        addr_r <= cmd_addr;
        wdata_r <= avs_writedata_i[CMD_WDATA_LSB +: DW];
        soft_pend_r <= cmd_soft;
      end else if (done) begin
        busy_r <= 1'b0;
        req_r <= 1'b0;
        soft_pend_r <= 1'b0;
        rdata_r <= we_r ? rdata_r : link.rdata;
      end
    end
  end

  assign avs_waitrequest_o = acc & ~ack_r;
  assign avs_readdata_o = rd_r;
  assign link.req = req_r;
  assign link.we = we_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign link.reset_pin = rst_pin_r;
endmodule // sfrm_ctrl

// File: test/sfrm_sva.sv
// Assertions on the link between monitor device and controller
`timescale 1ns/1ps
module sfrm_sva (
  input wire logic clock_i, // Clock
  input wire logic arst_n_i, // Reset, active low
  input wire logic req, // Request
  input wire logic we, // Direction
  input wire logic [2:0] addr, // Register index
  input wire logic [15:0] wdata, // Write data
  input wire logic ack, // Answer
  input wire logic reset_pin, // Reset pin
  input wire logic fault_pin // Fault pin
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  property p_walk;
    $rose(req) |-> !ack ##1 (ack && req) ##1 (!ack && !req);
  endproperty
  a_walk: assert property (p_walk)
    else $error("link transfer out of step");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_req;
    ack |-> req && $past(req) && !$past(ack);
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_hold;
    req && !ack |=> req && $stable({we, addr, wdata});
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_gap;
    ack |=> !req ##1 !ack;
  endproperty
  a_gap: assert property (p_gap)
    else $error("request not released after ack");
  property p_por;
    $rose(arst_n_i) |-> fault_pin ##1 fault_pin;
  endproperty
  a_por: assert property (p_por)
    else $error("fault pin low after power-on");
  property p_pin_rst;
    reset_pin [*5] |-> ##[0:6] fault_pin;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("pin reset did not raise fault");
  property p_sticky;
    fault_pin && !ack |=> fault_pin;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("fault dropped without a write");
endmodule // sfrm_sva

// File: test/supply_fault_reset_monitor_test.sv
// Self-checking bench of the monitor device and controller pair
`timescale 1ns/1ps
module supply_fault_reset_monitor_test;
  import sfrm_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [1:0] adr = 2'h0;
  logic rd = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdo;
  logic [31:0] r;
  logic wt;
  logic ce = 1'b1;
  logic ov = 1'b0, lv = 1'b0, uv = 1'b0, lsl = 1'b0;
  logic cuv = 1'b0, cov = 1'b0, auv = 1'b0, aov = 1'b0;
  logic [15:0] meas = 16'h0;
  logic [15:0] thr;
  logic [15:0] q;
  logic cen, aen, busy, done, inr;
  int bad_count = 0;
  int checked = 0;
  int seqs = 0;
  int n;
  sfrm_link_if lk ();
  sfrm_device #(.RST_FILT_CYC(4), .RETRY_CYC(8),
    .UNIT_CYC(16), .SEQ_CYC(8)) sfrm_device_i (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .ce_i(ce), .link(lk.dev),
    .stack_ov_cmp_i(ov), .stack_lv_cmp_i(lv), .stack_uv_cmp_i(uv),
    .logic_supply_low_i(lsl), .comm_ilim_uv_i(cuv), .comm_ov_cmp_i(cov),
    .ana_ilim_uv_i(auv), .ana_ov_cmp_i(aov), .meas_value_i(meas),
    .comm_reg_en_o(cen), .ana_reg_en_o(aen), .seq_busy_o(busy),
    .seq_done_o(done), .in_reset_o(inr));
  sfrm_ctrl #(.READY_CYC(20)) sfrm_ctrl_i (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr_en), .avs_writedata_i(wd),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wt), .link(lk.ctrl));
  sfrm_sva sfrm_sva_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .req(lk.req), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
    .ack(lk.ack), .reset_pin(lk.reset_pin), .fault_pin(lk.fault_pin));
  always #2.5 clock_i = ~clock_i;
  // A done pulse held through a freeze counts once
  always @(posedge clock_i) if (done === 1'b1 && ce) seqs <= seqs + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic av(input logic [1:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] o);
    int k = 0;
    @(posedge clock_i);
    adr <= a;
    rd <= !w;
    wr_en <= w;
    wd <= d;
    do begin
      @(posedge clock_i);
      k++;
    end while (wt !== 1'b0 && k < 200);
    if (k >= 200) bad_count++;
    o = rdo;
    rd <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic dev(input logic [2:0] i, input logic w,
                     input logic [15:0] d, output logic [15:0] o);
    int k = 0;
    av(HOST_CMD_IDX, 1'b1, {7'h0, w, 5'h0, i, d}, r);
    do begin
      av(HOST_STAT_IDX, 1'b0, 32'h0, r);
      k++;
    end while (r[0] !== 1'b0 && k < 50);
    if (k >= 50) bad_count++;
    av(HOST_RDATA_IDX, 1'b0, 32'h0, r);
    o = r[15:0];
  endtask
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    dev(i, 1'b1, d, q);
  endtask
  task automatic chk(input logic [2:0] i, input logic [15:0] e);
    dev(i, 1'b0, 16'h0, q);
    cmp($sformatf("reg%0d", i), e, q);
  endtask
  task automatic pin(input logic e);
    cmp("fault_pin", {15'h0, e}, {15'h0, lk.fault_pin});
  endtask
  task automatic pulse2(input int i);
    @(posedge clock_i);
    {auv, cov, cuv} <= 3'(1 << i);
    @(posedge clock_i);
    {auv, cov, cuv} <= 3'h0;
    repeat (3) @(posedge clock_i);
    if (i != 1) cmp("reg_on", 16'h0, {15'h0, i ? aen : cen});
    repeat (14) @(posedge clock_i);
    cmp("reg_on", 16'h1, {15'h0, i ? aen : cen});
    chk(IDX_FAULT2, 16'(1 << i));
    pin(1'b1);
    wr(IDX_FAULT2, 16'h0000);
    chk(IDX_FAULT2, 16'h0000);
    repeat (2) @(posedge clock_i);
    pin(1'b0);
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 5);
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(31));
    repeat (3) @(posedge clock_i);
    arst_n_i <= 1'b1;
    chk(IDX_FAULT1, FAULT1_POR_VAL);
    chk(IDX_FAULT2, FAULT2_RST_VAL);
    chk(IDX_MASK1, MASK1_RST_VAL);
    chk(IDX_SYSCFG1, CFG1_RST_VAL);
    chk(IDX_THRESH, THRESH_RST_VAL);
    chk(3'h7, 16'h0000);
    pin(1'b1);
    wr(IDX_FAULT1, 16'hfffe);
    chk(IDX_FAULT1, 16'h0000);
    fin("power_on");
    for (int i = 0; i < 3; i++) pulse2(i);
    fin("regulators");
    meas <= 16'($urandom);
    aov <= 1'b1;
    n = seqs;
    wr(IDX_SYSCFG1, 16'h0002);
    repeat (20) @(posedge clock_i);
    aov <= 1'b0;
    cmp("seqs", 16'(n + 1), 16'(seqs));
    cmp("seq_busy", 16'h0, {15'h0, busy});
    chk(IDX_FAULT2, 16'h0008);
    wr(IDX_FAULT2, 16'h0000);
    thr = 16'($urandom_range(16'h7fff));
    wr(IDX_THRESH, thr);
    // Equal value must not trip, a value 1 to 201 above must
    for (int k = 0; k < 2; k++) begin
      meas <= thr + 16'(k * (1 + $urandom_range(200)));
      n = seqs;
      wr(IDX_SYSCFG1, 16'h0010);
      repeat (100) @(posedge clock_i);
      cmp("cyclic", 16'h1, 16'(seqs - n >= 5));
      chk(IDX_FAULT2, k ? 16'h0010 : 16'h0000);
      wr(IDX_SYSCFG1, 16'h0000);
      wr(IDX_FAULT2, 16'h0000);
    end
    // Clock enable low must freeze the period timer and sequencer
    meas <= 16'h0000;
    wr(IDX_SYSCFG1, 16'h0010);
    ce <= 1'b0;
    @(posedge clock_i);
    n = seqs;
    repeat (50) @(posedge clock_i);
    cmp("frozen", 16'(n), 16'(seqs));
    ce <= 1'b1;
    repeat (40) @(posedge clock_i);
    cmp("resumed", 16'h1, 16'(seqs - n >= 1));
    wr(IDX_SYSCFG1, 16'h0000);
    repeat (20) @(posedge clock_i);
    n = seqs;
    repeat (50) @(posedge clock_i);
    cmp("idle", 16'(n), 16'(seqs));
    fin("sequences");
    ov <= 1'b1;
    repeat (SUPPLY_FILTER_CYC) @(posedge clock_i);
    ov <= 1'b0;
    chk(IDX_FAULT1, 16'h0000);
    ov <= 1'b1;
    repeat (SUPPLY_FILTER_CYC + 1) @(posedge clock_i);
    ov <= 1'b0;
    chk(IDX_FAULT1, 16'h0004);
    pin(1'b1);
    cmp("in_reset", 16'h0, {15'h0, inr});
    wr(IDX_MASK1, 16'h0004);
    repeat (2) @(posedge clock_i);
    pin(1'b0);
    wr(IDX_MASK1, 16'h0000);
    lv <= 1'b1;
    wr(IDX_FAULT1, 16'hfff7);
    chk(IDX_FAULT1, 16'h000c);
    lv <= 1'b0;
    wr(IDX_FAULT1, 16'hfff7);
    chk(IDX_FAULT1, 16'h0004);
    fin("stack_supply");
    wr(IDX_THRESH, 16'h0123);
    // Mask the first status so only the reset can raise the pin
    wr(IDX_MASK1, 16'h000f);
    av(HOST_RSTPIN_IDX, 1'b1, 32'h1, r);
    av(HOST_RSTPIN_IDX, 1'b1, 32'h0, r);
    chk(IDX_FAULT1, 16'h0004);
    pin(1'b0);
    av(HOST_RSTPIN_IDX, 1'b1, 32'h1, r);
    repeat (10) @(posedge clock_i);
    av(HOST_RSTPIN_IDX, 1'b1, 32'h0, r);
    chk(IDX_FAULT1, 16'h0006);
    chk(IDX_THRESH, THRESH_RST_VAL);
    pin(1'b1);
    wr(IDX_FAULT1, 16'hfffd);
    wr(IDX_MASK1, 16'h0f0f);
    wr(IDX_SYSCFG1, 16'h0001);
    chk(IDX_FAULT1, 16'h0006);
    chk(IDX_MASK1, MASK1_RST_VAL);
    fin("resets");
    wr(IDX_FAULT1, 16'h0000);
    lsl <= 1'b1;
    @(posedge clock_i);
    lsl <= 1'b0;
    chk(IDX_FAULT1, FAULT1_POR_VAL);
    wr(IDX_FAULT1, 16'h0000);
    uv <= 1'b1;
    repeat (3) @(posedge clock_i);
    cmp("in_reset", 16'h1, {15'h0, inr});
    uv <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(IDX_FAULT1, FAULT1_POR_VAL);
    fin("power_drop");
    results();
  end
endmodule // supply_fault_reset_monitor_test
